// *** inc/fpusr_pkg.sv ***
// Package with constants and types of the floating-point state registers
package fpusr_pkg;
    localparam int NUM_REGS = 8;
    localparam logic [15:0] TAG_RESET = 16'hFFFF;
    localparam logic [15:0] CTRL_RESET = 16'h037F;
    localparam int INFINITY_BIT = 12;
    localparam logic [1:0] TAG_VALID = 2'h0;
    localparam logic [1:0] TAG_ZERO = 2'h1;
    localparam logic [1:0] TAG_SPECIAL = 2'h2;
    localparam logic [1:0] TAG_EMPTY = 2'h3;
    localparam logic [4:0] OPCODE_FIXED = 5'h1B;
    localparam int OFFSET_LSB = 0;
    localparam int SELECTOR_LSB = 32;
    localparam int IMAGE_WORDS = 7;
    localparam logic [2:0] IMG_CONTROL = 3'h0;
    localparam logic [2:0] IMG_STATUS = 3'h1;
    localparam logic [2:0] IMG_TAG = 3'h2;
    localparam logic [2:0] IMG_IP_OFFSET = 3'h3;
    localparam logic [2:0] IMG_IP_SEL_OPC = 3'h4;
    localparam logic [2:0] IMG_OP_OFFSET = 3'h5;
    localparam logic [2:0] IMG_OP_SEL = 3'h6;
    localparam logic [3:0] DATA_WORDS = 4'h3;

    typedef enum logic [3:0]
    {
        OP_NONE = 4'h0,
        OP_ARITH = 4'h1,
        OP_PUSH = 4'h2,
        OP_POP = 4'h3,
        OP_INIT = 4'h4,
        OP_SAVE = 4'h5,
        OP_RESTORE = 4'h6,
        OP_ENV_STORE = 4'h7,
        OP_ENV_LOAD = 4'h8,
        OP_CONTROL = 4'h9
    } fpusr_op_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_STORE = 2'h1,
        ST_LOAD = 2'h2
    } fpusr_state_t;

    typedef struct packed
    {
        fpusr_op_t op;
        logic [2:0] srcReg;
        logic srcUsed;
        logic hasMemOperand;
        logic [47:0] instrPointer;
        logic [47:0] operandPointer;
        logic [10:0] opcode;
        logic [79:0] pushValue;
        logic protectedMode;
        logic operandSize32;
    } fpusr_cmd_t;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [6:0] index;
        logic [31:0] data;
    } fpusr_mem_t;
endpackage

// *** core/fpusr_state_regs.sv ***
// Tag, pointer, opcode and control state of the floating-point unit
// How it works
// - Infinity control bit stored, never used
// - Tag word: eight two-bit tags
// - Init or full save sets tags FFFF
// - Tags: 00 valid, 01 zero, 10 special
// - Push onto non-empty register flags overflow
// - Pop whose new top register is empty, or source on empty, flags underflow
// - Loaded tag: empty stays, else derived
// - Tags readable through state store and the registerTagWord output
// - 48-bit instruction and operand pointers captured
// - Control instructions leave pointers unchanged
// - Operand pointer undefined without memory operand
// - Offset bits 0-31, selector bits 32-47
// - Init and full save clear pointers
// - Instruction pointer addresses first prefix
// - Opcode keeps eleven bits, fixed 11011
// - Store writes environment, save adds data
// - Full save then reinitializes state
// - Image layout from mode and size
// - Protected 32-bit image word order
// - Env load reloads environment, restore adds data
// - Data registers hold 80-bit extended values
// - Memory words least significant byte first
// - Init and save set control 037F
`timescale 1ns/10ps
`default_nettype none
module fpusr_state_regs
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Instruction from the processor core
    input wire logic cmdValid,
    input wire fpusr_pkg::fpusr_cmd_t cmd,
    output logic cmdReady,
    // Memory word traffic, one 32-bit word per index
    output fpusr_pkg::fpusr_mem_t memReq,
    input wire logic [31:0] memReadData,
    // Visible state
    output logic [15:0] registerTagWord,
    output logic [15:0] controlWord,
    output logic [2:0] stackTop,
    output logic stackOverflow,
    output logic stackUnderflow,
    output logic [79:0] stackTopRegister
);

    // Stack depth, one 80-bit register per tag
    localparam int NUM_DATA = fpusr_pkg::NUM_REGS;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed
    {
        fpusr_pkg::fpusr_state_t state;
        logic [6:0] idx;
        logic fullOp;
        logic layout32Prot;
        logic [15:0] tags;
        logic [15:0] control;
        logic [15:0] status;
        logic [47:0] lastInstructionPointer;
        logic [47:0] lastOperandPointer;
        logic [10:0] lastOpcode;
        logic [15:0] tagImage;
        logic [NUM_DATA*80-1:0] data;
        logic overflow;
        logic underflow;
        logic ready;
        fpusr_pkg::fpusr_mem_t mem;
    } fpusr_regs_t;

    fpusr_regs_t r;
    fpusr_regs_t next_r;

    // Tag derived from an 80-bit value
    function automatic logic [1:0] classify(input logic [79:0] v);
        logic [1:0] t;
        t = fpusr_pkg::TAG_VALID;
        if (v[78:0] == 79'h0)
        begin
            t = fpusr_pkg::TAG_ZERO;
        end
        else if (v[78:64] == 15'h7FFF || v[78:64] == 15'h0 || !v[63])
        begin
            t = fpusr_pkg::TAG_SPECIAL;
        end
        return t;
    endfunction

    logic [2:0] pushSlot;
    logic [2:0] popSlot;
    logic [2:0] topSlot;
    logic [6:0] lastIdx;
    logic [31:0] envWord;
    logic [2:0] dataReg;
    logic [1:0] dataPart;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        topSlot = r.status[13:11];
        pushSlot = topSlot - 3'h1;
        popSlot = topSlot + 3'h1;
        lastIdx = r.fullOp ? 7'(fpusr_pkg::IMAGE_WORDS + NUM_DATA * 3 - 1) : 7'(fpusr_pkg::IMAGE_WORDS - 1);
        dataReg = 3'((r.idx - 7'(fpusr_pkg::IMAGE_WORDS)) / 7'h3);
        dataPart = 2'((r.idx - 7'(fpusr_pkg::IMAGE_WORDS)) % 7'h3);
        envWord = 32'h0;
        next_r.mem.valid = 1'b0;
        next_r.overflow = 1'b0;
        next_r.underflow = 1'b0;
        // Image word for the current index; 16-bit and real-mode forms keep the same order
        case (r.idx[2:0])
            fpusr_pkg::IMG_CONTROL: envWord = {16'h0, r.control};
            fpusr_pkg::IMG_STATUS: envWord = {16'h0, r.status};
            fpusr_pkg::IMG_TAG: envWord = {16'h0, r.tags};
            fpusr_pkg::IMG_IP_OFFSET: envWord = r.lastInstructionPointer[31:0];
            fpusr_pkg::IMG_IP_SEL_OPC: envWord = r.layout32Prot ?
                {5'h0, r.lastOpcode, r.lastInstructionPointer[47:32]} :
                {5'h0, r.lastOpcode, 16'h0};
            fpusr_pkg::IMG_OP_OFFSET: envWord = r.lastOperandPointer[31:0];
            fpusr_pkg::IMG_OP_SEL: envWord = r.layout32Prot ? {16'h0, r.lastOperandPointer[47:32]} : 32'h0;
            default: envWord = 32'h0;
        endcase
        case (r.state)
            fpusr_pkg::ST_IDLE:
            begin
                next_r.ready = 1'b1;
                if (cmdValid && r.ready)
                begin
                    next_r.layout32Prot = cmd.protectedMode && cmd.operandSize32;
                    next_r.idx = 7'h0;
                    // Non-control instructions capture pointers and opcode
                    if (cmd.op == fpusr_pkg::OP_ARITH || cmd.op == fpusr_pkg::OP_PUSH || cmd.op == fpusr_pkg::OP_POP)
                    begin
                        next_r.lastInstructionPointer = cmd.instrPointer;
                        next_r.lastOpcode = cmd.opcode;
                        if (cmd.hasMemOperand)
                        begin
                            next_r.lastOperandPointer = cmd.operandPointer;
                        end
                        if (cmd.srcUsed && r.tags[2*cmd.srcReg +: 2] == fpusr_pkg::TAG_EMPTY)
                        begin
                            next_r.underflow = 1'b1;
                        end
                    end
                    case (cmd.op)
                        fpusr_pkg::OP_PUSH:
                        begin
                            if (r.tags[2*pushSlot +: 2] != fpusr_pkg::TAG_EMPTY)
                            begin
                                next_r.overflow = 1'b1;
                            end
                            next_r.status[13:11] = pushSlot;
                            next_r.data[80*pushSlot +: 80] = cmd.pushValue;
                            next_r.tags[2*pushSlot +: 2] = classify(cmd.pushValue);
                        end
                        fpusr_pkg::OP_POP:
                        begin
                            next_r.tags[2*topSlot +: 2] = fpusr_pkg::TAG_EMPTY;
                            next_r.status[13:11] = popSlot;
                            if (r.tags[2*popSlot +: 2] == fpusr_pkg::TAG_EMPTY)
                            begin
                                next_r.underflow = 1'b1;
                            end
                        end
                        fpusr_pkg::OP_INIT:
                        begin
                            next_r.control = fpusr_pkg::CTRL_RESET;
                            next_r.status = 16'h0;
                            next_r.tags = fpusr_pkg::TAG_RESET;
                            next_r.lastInstructionPointer = 48'h0;
                            next_r.lastOperandPointer = 48'h0;
                            next_r.lastOpcode = 11'h0;
                        end
                        fpusr_pkg::OP_SAVE, fpusr_pkg::OP_ENV_STORE:
                        begin
                            next_r.state = fpusr_pkg::ST_STORE;
                            next_r.fullOp = (cmd.op == fpusr_pkg::OP_SAVE);
                            next_r.ready = 1'b0;
                        end
                        fpusr_pkg::OP_RESTORE, fpusr_pkg::OP_ENV_LOAD:
                        begin
                            next_r.state = fpusr_pkg::ST_LOAD;
                            next_r.fullOp = (cmd.op == fpusr_pkg::OP_RESTORE);
                            next_r.ready = 1'b0;
                            next_r.mem.valid = 1'b1;
                            next_r.mem.write = 1'b0;
                            next_r.mem.index = 7'h0;
                        end
                        default:
                        begin
                            next_r.status = r.status;
                        end
                    endcase
                end
            end
            fpusr_pkg::ST_STORE:
            begin
                next_r.mem.valid = 1'b1;
                next_r.mem.write = 1'b1;
                next_r.mem.index = r.idx;
                // Data values go out least significant word first
                if (r.idx < 7'(fpusr_pkg::IMAGE_WORDS))
                begin
                    next_r.mem.data = envWord;
                end
                else
                begin
                    next_r.mem.data = (dataPart == 2'h2) ? {16'h0, r.data[80*dataReg+64 +: 16]} :
                        r.data[80*dataReg+32*dataPart +: 32];
                end
                next_r.idx = r.idx + 7'h1;
                if (r.idx == lastIdx)
                begin
                    next_r.state = fpusr_pkg::ST_IDLE;
                    if (r.fullOp)
                    begin
                        next_r.control = fpusr_pkg::CTRL_RESET;
                        next_r.status = 16'h0;
                        next_r.tags = fpusr_pkg::TAG_RESET;
                        next_r.lastInstructionPointer = 48'h0;
                        next_r.lastOperandPointer = 48'h0;
                        next_r.lastOpcode = 11'h0;
                    end
                end
            end
            fpusr_pkg::ST_LOAD:
            begin
                // Memory answers r.idx in the cycle that requests it
                if (r.idx < 7'(fpusr_pkg::IMAGE_WORDS))
                begin
                    case (r.idx[2:0])
                        fpusr_pkg::IMG_CONTROL: next_r.control = memReadData[15:0];
                        fpusr_pkg::IMG_STATUS: next_r.status = memReadData[15:0];
                        fpusr_pkg::IMG_TAG: next_r.tagImage = memReadData[15:0];
                        fpusr_pkg::IMG_IP_OFFSET: next_r.lastInstructionPointer[31:0] = memReadData;
                        fpusr_pkg::IMG_IP_SEL_OPC:
                        begin
                            next_r.lastOpcode = memReadData[26:16];
                            if (r.layout32Prot)
                            begin
                                next_r.lastInstructionPointer[47:32] = memReadData[15:0];
                            end
                        end
                        fpusr_pkg::IMG_OP_OFFSET: next_r.lastOperandPointer[31:0] = memReadData;
                        fpusr_pkg::IMG_OP_SEL:
                        begin
                            if (r.layout32Prot)
                            begin
                                next_r.lastOperandPointer[47:32] = memReadData[15:0];
                            end
                        end
                        default: next_r.lastOpcode = r.lastOpcode;
                    endcase
                end
                else if (dataPart == 2'h2)
                begin
                    next_r.data[80*dataReg+64 +: 16] = memReadData[15:0];
                end
                else
                begin
                    next_r.data[80*dataReg+32*dataPart +: 32] = memReadData;
                end
                next_r.idx = r.idx + 7'h1;
                if (r.idx == lastIdx)
                begin
                    next_r.state = fpusr_pkg::ST_IDLE;
                    // Tags rebuilt from image and actual data
                    for (int i = 0; i < NUM_DATA; i++)
                    begin
                        if (r.tagImage[2*i +: 2] == fpusr_pkg::TAG_EMPTY)
                        begin
                            next_r.tags[2*i +: 2] = fpusr_pkg::TAG_EMPTY;
                        end
                        else
                        begin
                            next_r.tags[2*i +: 2] = classify(next_r.data[80*i +: 80]);
                        end
                    end
                end
                else
                begin
                    next_r.mem.valid = 1'b1;
                    next_r.mem.write = 1'b0;
                    next_r.mem.index = r.idx + 7'h1;
                end
            end
            default: next_r.state = fpusr_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
            r.tags <= fpusr_pkg::TAG_RESET;
            r.control <= fpusr_pkg::CTRL_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [79:0] topValue;
    // Taken from the next state so the output leaves a flip-flop
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            topValue <= 80'h0;
        end
        else
        begin
            topValue <= next_r.data[80*next_r.status[13:11] +: 80];
        end
    end

    assign cmdReady = r.ready;
    assign memReq = r.mem;
    assign registerTagWord = r.tags;
    assign controlWord = r.control;
    assign stackTop = r.status[13:11];
    assign stackOverflow = r.overflow;
    assign stackUnderflow = r.underflow;
    assign stackTopRegister = topValue;
endmodule
`default_nettype wire

// *** tb/fpusr_state_regs_assertions.sv ***
// Checker for the floating-point state registers, bound to the design
`timescale 1ns/10ps
`default_nettype none
module fpusr_state_regs_assertions
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Command port
    input wire logic cmdValid,
    input wire fpusr_pkg::fpusr_cmd_t cmd,
    input wire logic cmdReady,
    // Memory port
    input wire fpusr_pkg::fpusr_mem_t memReq,
    input wire logic [31:0] memReadData,
    // Visible state
    input wire logic [15:0] registerTagWord,
    input wire logic [15:0] controlWord,
    input wire logic [2:0] stackTop,
    input wire logic stackOverflow,
    input wire logic stackUnderflow,
    input wire logic [79:0] stackTopRegister
);
    logic take;
    logic [2:0] downIdx;
    logic [2:0] upIdx;
    logic [1:0] downTag;
    logic [1:0] upTag;
    assign take = cmdValid && cmdReady;
    assign downIdx = stackTop - 3'h1;
    assign upIdx = stackTop + 3'h1;
    assign downTag = registerTagWord[{downIdx, 1'h0} +: 2];
    assign upTag = registerTagWord[{upIdx, 1'h0} +: 2];
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // ------------------------------
    // Assertions
    // ------------------------------
    a_init_defaults: assert property (take && cmd.op == fpusr_pkg::OP_INIT
        |=> registerTagWord == 16'hFFFF && controlWord == 16'h037F) else $error("init defaults wrong");
    a_push_overflow: assert property (take && cmd.op == fpusr_pkg::OP_PUSH
        |=> stackOverflow == ($past(downTag) != 2'h3) && stackTop == $past(downIdx)) else $error("push flag wrong");
    a_pop_underflow: assert property (take && cmd.op == fpusr_pkg::OP_POP && !cmd.srcUsed
        |=> stackUnderflow == ($past(upTag) == 2'h3)) else $error("pop flag wrong");
    a_store_words: assert property (take && cmd.op == fpusr_pkg::OP_ENV_STORE
        |-> ##2 (memReq.valid && memReq.write)[*7] ##1 !memReq.valid) else $error("store length wrong");
    a_save_words: assert property (take && cmd.op == fpusr_pkg::OP_SAVE
        |-> ##32 memReq.valid && memReq.index == 7'h1E ##1 !memReq.valid) else $error("save length wrong");
    a_load_reads: assert property (take && cmd.op == fpusr_pkg::OP_ENV_LOAD
        |=> (memReq.valid && !memReq.write)[*7] ##1 !memReq.valid) else $error("load length wrong");
    a_image_tag: assert property (memReq.valid && memReq.write && memReq.index == 7'h02
        |-> memReq.data[15:0] == registerTagWord) else $error("tag image word wrong");
    a_image_ctrl: assert property (memReq.valid && memReq.write && memReq.index == 7'h00
        |-> memReq.data[15:0] == controlWord) else $error("control image word wrong");
    a_save_reinit: assert property (take && cmd.op == fpusr_pkg::OP_SAVE
        |-> ##[32:34] registerTagWord == 16'hFFFF && controlWord == 16'h037F) else $error("save reinit wrong");
    c_save: cover property (take && cmd.op == fpusr_pkg::OP_SAVE);
    c_overflow: cover property (stackOverflow);
    c_underflow: cover property (stackUnderflow);
endmodule
bind fpusr_state_regs fpusr_state_regs_assertions chk
(
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cmdValid(cmdValid),
    .cmd(cmd),
    .cmdReady(cmdReady),
    .memReq(memReq),
    .memReadData(memReadData),
    .registerTagWord(registerTagWord),
    .controlWord(controlWord),
    .stackTop(stackTop),
    .stackOverflow(stackOverflow),
    .stackUnderflow(stackUnderflow),
    .stackTopRegister(stackTopRegister)
);
`default_nettype wire

// *** tb/fpusr_mem_model.sv ***
// Memory model answering the unit's word traffic
`timescale 1ns/10ps
`default_nettype none
module fpusr_mem_model
(
    // Clock
    input wire logic ref_clk,
    // Word traffic
    input wire fpusr_pkg::fpusr_mem_t memReq,
    output logic [31:0] memReadData
);
    logic [31:0] mem [0:127];
    initial
    begin
        for (int i = 0; i < 128; i++) mem[i] = 32'h0;
    end
    // Read data answers within the requesting cycle; other cycles show the inverse so stale data never matches
    assign memReadData = (memReq.valid && !memReq.write) ? mem[memReq.index] : ~mem[memReq.index];
    always @(posedge ref_clk)
    begin
        if (memReq.valid && memReq.write)
            mem[memReq.index] <= memReq.data;
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench of the floating-point state registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic cmdValid = 1'h0;
    fpusr_pkg::fpusr_cmd_t cmd = '0;
    logic cmdReady;
    fpusr_pkg::fpusr_mem_t memReq;
    logic [31:0] memReadData;
    logic [15:0] registerTagWord;
    logic [15:0] controlWord;
    logic [2:0] stackTop;
    logic stackOverflow;
    logic stackUnderflow;
    logic [79:0] stackTopRegister;
    logic ovf;
    logic unf;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [79:0] NORM = {16'h3FFF, 64'h8000000000000000};
    localparam logic [79:0] ZERO = 80'h0;
    localparam logic [79:0] SPEC = {16'h7FFF, 64'hC000000000000000};
    always #50 ref_clk = ~ref_clk;
    fpusr_state_regs dut
    (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cmdValid(cmdValid),
        .cmd(cmd),
        .cmdReady(cmdReady),
        .memReq(memReq),
        .memReadData(memReadData),
        .registerTagWord(registerTagWord),
        .controlWord(controlWord),
        .stackTop(stackTop),
        .stackOverflow(stackOverflow),
        .stackUnderflow(stackUnderflow),
        .stackTopRegister(stackTopRegister)
    );
    fpusr_mem_model mdl
    (
        .ref_clk(ref_clk),
        .memReq(memReq),
        .memReadData(memReadData)
    );
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Offer one command, wait for its take, then for the port to be free
    task automatic issue(input fpusr_pkg::fpusr_op_t op, input logic [79:0] val);
        int n;
        n = 0;
        cmd.op = op;
        cmd.pushValue = val;
        cmdValid = 1'h1;
        @(posedge ref_clk);
        #1;
        cmdValid = 1'h0;
        ovf = stackOverflow;
        unf = stackUnderflow;
        repeat (2) @(posedge ref_clk);
        #1;
        while (cmdReady !== 1'h1 && n < 60)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("cmdReady", 80'(cmdReady), 80'h1);
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    // ------------------------------
    // Tests
    // ------------------------------
    initial
    begin
        repeat (6) @(posedge ref_clk);
        #1;
        reset_n = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1;
        check("tags", 80'(registerTagWord), 80'hFFFF);
        check("control", 80'(controlWord), 80'h037F);
        cmd.instrPointer = 48'h123489ABCDEF;
        cmd.operandPointer = 48'h567801020304;
        cmd.hasMemOperand = 1'h1;
        cmd.opcode = 11'h5A5;
        cmd.protectedMode = 1'h1;
        cmd.operandSize32 = 1'h1;
        issue(fpusr_pkg::OP_PUSH, NORM);
        issue(fpusr_pkg::OP_PUSH, ZERO);
        issue(fpusr_pkg::OP_PUSH, SPEC);
        check("tags", 80'(registerTagWord), 80'h1BFF);
        check("top", 80'(stackTop), 80'h5);
        check("st0", stackTopRegister, SPEC);
        cmd.instrPointer = '1;
        cmd.operandPointer = '1;
        issue(fpusr_pkg::OP_CONTROL, ZERO);
        issue(fpusr_pkg::OP_ENV_STORE, ZERO);
        check("w2", 80'(mdl.mem[2][15:0]), 80'h1BFF);
        check("w3", 80'(mdl.mem[3]), 80'h89ABCDEF);
        check("w4", 80'(mdl.mem[4]), 80'({5'h00, 11'h5A5, 16'h1234}));
        check("w5", 80'(mdl.mem[5]), 80'h01020304);
        check("w6", 80'(mdl.mem[6][15:0]), 80'h5678);
        $display("test image done");
        repeat (5) issue(fpusr_pkg::OP_PUSH, NORM);
        check("ovf", 80'(ovf), 80'h0);
        issue(fpusr_pkg::OP_PUSH, NORM);
        check("ovf", 80'(ovf), 80'h1);
        issue(fpusr_pkg::OP_POP, ZERO);
        check("unf", 80'(unf), 80'h0);
        issue(fpusr_pkg::OP_SAVE, ZERO);
        check("d7lo", 80'(mdl.mem[28]), 80'h0);
        check("d7mid", 80'(mdl.mem[29]), 80'h80000000);
        check("d7hi", 80'(mdl.mem[30][15:0]), 80'h3FFF);
        check("tags", 80'(registerTagWord), 80'hFFFF);
        check("control", 80'(controlWord), 80'h037F);
        issue(fpusr_pkg::OP_ENV_STORE, ZERO);
        check("ipoff", 80'(mdl.mem[3]), 80'h0);
        check("opoff", 80'(mdl.mem[5]), 80'h0);
        $display("test save done");
        issue(fpusr_pkg::OP_INIT, ZERO);
        issue(fpusr_pkg::OP_POP, ZERO);
        check("unf", 80'(unf), 80'h1);
        mdl.mem[0] = 32'h1A7F;
        mdl.mem[1] = 32'h3800;
        mdl.mem[2] = 32'h3FFF;
        mdl.mem[29] = 32'h0;
        mdl.mem[30] = 32'h0;
        issue(fpusr_pkg::OP_RESTORE, ZERO);
        check("tags", 80'(registerTagWord), 80'h7FFF);
        check("control", 80'(controlWord), 80'h1A7F);
        check("top", 80'(stackTop), 80'h7);
        check("st0", stackTopRegister, ZERO);
        mdl.mem[2] = 32'hFFFF;
        issue(fpusr_pkg::OP_ENV_LOAD, ZERO);
        check("tags", 80'(registerTagWord), 80'hFFFF);
        $display("test restore done");
        issue(fpusr_pkg::OP_INIT, ZERO);
        check("control", 80'(controlWord), 80'h037F);
        cmd.opcode = 11'h123;
        cmd.srcUsed = 1'h1;
        cmd.srcReg = 3'h3;
        issue(fpusr_pkg::OP_ARITH, ZERO);
        check("unf", 80'(unf), 80'h1);
        cmd.protectedMode = 1'h0;
        issue(fpusr_pkg::OP_ENV_STORE, ZERO);
        check("w3", 80'(mdl.mem[3]), 80'hFFFFFFFF);
        check("w4", 80'(mdl.mem[4]), 80'h01230000);
        check("w6", 80'(mdl.mem[6]), 80'h0);
        $display("test mode done");
        stop_test();
    end
endmodule
`default_nettype wire
